/* File: core/sem_host_pkg.sv */
`default_nettype none
package sem_host_pkg;
  // ==========================================
  // Widths and encodings
  localparam int             FLAG_COUNT  = 8;
  localparam int             INDEX_W     = 3;
  localparam int             ADDR_W      = 12;
  localparam int             DATA_W      = 16;
  localparam logic [1:0]     OP_ACQUIRE  = 2'h0;
  localparam logic [1:0]     OP_RELEASE  = 2'h1;
  localparam logic [1:0]     OP_READ     = 2'h2;
  localparam logic [1:0]     OP_INIT     = 2'h3;
  localparam logic           FLAG_TAKEN  = 1'h0;
  localparam logic           FLAG_FREE   = 1'h1;
  // ==========================================
  // Timing
  localparam int             CLK_PERIOD_NS = 10;
  localparam int             T_WRITE_NS    = 60;
  localparam int             T_READ_NS     = 60;
  localparam int             T_GAP_NS      = 20;
  localparam int             SYNC_CYC      = 2;
  localparam int             WRITE_CYC     = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int             READ_CYC      = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                             + SYNC_CYC;
  localparam int             GAP_CYC       = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int             TMR_W         = 8;
  localparam int             POLL_W        = 8;
  localparam logic [POLL_W-1:0] POLL_DEFAULT = 8'h04;
  // ==========================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WRITE,
    ST_WEND,
    ST_READ,
    ST_GAP
  } phase_t;
endpackage
`default_nettype wire

/* File: core/pin_sync.sv */
`default_nettype none
module pin_sync #(
  parameter int W = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* File: core/sem_host.sv */
`default_nettype none
module sem_host #(
  parameter logic [sem_host_pkg::POLL_W-1:0] POLL_LIMIT = sem_host_pkg::POLL_DEFAULT
) (
  input  wire logic                               sys_clk,
  input  wire logic                               rst,
  // User command side
  input  wire logic                               cmd_valid,
  input  wire logic [1:0]                         cmd_op,
  input  wire logic [sem_host_pkg::INDEX_W-1:0]   cmd_index,
  output var  logic                               cmd_ready,
  output var  logic                               done,
  output var  logic                               granted,
  output var  logic                               flag_value,
  output var  logic                               read_mismatch,
  // Device port pins
  output var  logic                               chip_enable_n,
  output var  logic                               semaphore_select_n,
  output var  logic                               output_enable_n,
  output var  logic                               read_write_n,
  output var  logic [sem_host_pkg::ADDR_W-1:0]    addr,
  input  wire logic [sem_host_pkg::DATA_W-1:0]    data_in,
  output var  logic [sem_host_pkg::DATA_W-1:0]    data_out,
  output var  logic                               data_oe
);
  sem_host_pkg::phase_t                   phase_reg;
  logic [1:0]                             op_reg;
  logic [sem_host_pkg::INDEX_W-1:0]       idx_reg;
  logic                                   wval_reg;
  logic                                   withdraw_reg;
  logic [sem_host_pkg::TMR_W-1:0]         tmr_reg;
  logic [sem_host_pkg::POLL_W-1:0]        polls_reg;
  logic [sem_host_pkg::DATA_W-1:0]        data_sync;
  logic                                   tmr_end;
  logic                                   idle_take;
  logic                                   last_index;
  logic                                   boot_reg;
  logic                                   checked_reg;

  // ==========================================
  // Data bus synchroniser
  pin_sync #(
    .W (sem_host_pkg::DATA_W)
  ) u_data_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (data_in),
    .q       (data_sync)
  );

  function automatic logic [sem_host_pkg::TMR_W-1:0] phase_len(
    input sem_host_pkg::phase_t ph
  );
    case (ph)
      sem_host_pkg::ST_WRITE: phase_len = sem_host_pkg::TMR_W'(sem_host_pkg::WRITE_CYC - 1);
      sem_host_pkg::ST_READ:  phase_len = sem_host_pkg::TMR_W'(sem_host_pkg::READ_CYC - 1);
      sem_host_pkg::ST_GAP:   phase_len = sem_host_pkg::TMR_W'(sem_host_pkg::GAP_CYC - 1);
      default:                phase_len = '0;
    endcase
  endfunction

  assign tmr_end    = (tmr_reg == phase_len(phase_reg));
  assign idle_take  = (phase_reg == sem_host_pkg::ST_IDLE) && cmd_valid && cmd_ready;
  assign last_index = (idx_reg == sem_host_pkg::INDEX_W'(sem_host_pkg::FLAG_COUNT - 1));

  // ==========================================
  // Phase timer
  always_ff @(posedge sys_clk) begin
    if (rst || tmr_end || phase_reg == sem_host_pkg::ST_IDLE ||
        phase_reg == sem_host_pkg::ST_WEND) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tmr_reg + 1'b1;
    end
  end

  // ==========================================
  // Sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_reg    <= sem_host_pkg::ST_IDLE;
      op_reg       <= sem_host_pkg::OP_INIT;
      idx_reg      <= '0;
      wval_reg     <= sem_host_pkg::FLAG_FREE;
      withdraw_reg <= 1'b0;
      polls_reg    <= '0;
      cmd_ready    <= 1'b0;
      done         <= 1'b0;
      granted      <= 1'b0;
      flag_value   <= sem_host_pkg::FLAG_FREE;
      read_mismatch <= 1'b0;
      boot_reg     <= 1'b1;
      checked_reg  <= 1'b0;
    end else begin
      done <= 1'b0;
      case (phase_reg)
        sem_host_pkg::ST_IDLE: begin
          if (op_reg == sem_host_pkg::OP_INIT) begin
            wval_reg  <= sem_host_pkg::FLAG_FREE;
            phase_reg <= sem_host_pkg::ST_WRITE;
          end else if (idle_take) begin
            cmd_ready    <= 1'b0;
            op_reg       <= cmd_op;
            idx_reg      <= (cmd_op == sem_host_pkg::OP_INIT) ? '0 : cmd_index;
            withdraw_reg <= 1'b0;
            checked_reg  <= 1'b0;
            polls_reg    <= POLL_LIMIT;
            granted      <= 1'b0;
            if (cmd_op == sem_host_pkg::OP_READ) begin
              phase_reg <= sem_host_pkg::ST_READ;
            end else begin
              // Acquire writes zero before any read-back
              wval_reg  <= (cmd_op == sem_host_pkg::OP_ACQUIRE) ? sem_host_pkg::FLAG_TAKEN
                                                                 : sem_host_pkg::FLAG_FREE;
              phase_reg <= sem_host_pkg::ST_WRITE;
            end
          end else begin
            cmd_ready <= 1'b1;
          end
        end
        sem_host_pkg::ST_WRITE: begin
          if (tmr_end) begin
            phase_reg <= sem_host_pkg::ST_WEND;
          end
        end
        sem_host_pkg::ST_WEND: begin
          phase_reg <= sem_host_pkg::ST_GAP;
        end
        sem_host_pkg::ST_READ: begin
          if (tmr_end) begin
            flag_value    <= data_sync[0];
            read_mismatch <= (|data_sync) && !(&data_sync);
            phase_reg     <= sem_host_pkg::ST_GAP;
          end
        end
        sem_host_pkg::ST_GAP: begin
          if (tmr_end) begin
            phase_reg <= sem_host_pkg::ST_IDLE;
            if (op_reg == sem_host_pkg::OP_INIT) begin
              if (last_index) begin
                op_reg <= sem_host_pkg::OP_READ;
                idx_reg <= '0;
                // No done pulse for the automatic start-up pass
                done     <= !boot_reg;
                boot_reg <= 1'b0;
              end else begin
                idx_reg   <= idx_reg + 1'b1;
                phase_reg <= sem_host_pkg::ST_WRITE;
              end
            end else if (op_reg == sem_host_pkg::OP_ACQUIRE && !withdraw_reg) begin
              if (!checked_reg) begin
                // Fresh read-back, never a stale flag value
                checked_reg <= 1'b1;
                phase_reg   <= sem_host_pkg::ST_READ;
              end else if (flag_value == sem_host_pkg::FLAG_TAKEN) begin
                granted <= 1'b1;
                done    <= 1'b1;
              end else if (polls_reg != '0) begin
                polls_reg <= polls_reg - 1'b1;      // Keep polling
                phase_reg <= sem_host_pkg::ST_READ;
              end else begin
                withdraw_reg <= 1'b1;               // Withdraw pending request
                wval_reg     <= sem_host_pkg::FLAG_FREE;
                phase_reg    <= sem_host_pkg::ST_WRITE;
              end
            end else begin
              done <= 1'b1;
            end
          end
        end
        default: begin
          phase_reg <= sem_host_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Pin drive
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chip_enable_n      <= 1'b1;
      semaphore_select_n <= 1'b1;
      output_enable_n    <= 1'b1;
      read_write_n       <= 1'b1;
      addr               <= '0;
      data_out           <= '0;
      data_oe            <= 1'b0;
    end else begin
      chip_enable_n <= 1'b1;                          // Array never touched
      addr          <= {{(sem_host_pkg::ADDR_W - sem_host_pkg::INDEX_W){1'b0}}, idx_reg};
      data_out      <= {sem_host_pkg::DATA_W{wval_reg}};
      // Select plus R/W strobe, SRAM style
      semaphore_select_n <= !(phase_reg == sem_host_pkg::ST_WRITE ||
                              phase_reg == sem_host_pkg::ST_READ);
      // Strobe and select end together, data held one cycle longer
      read_write_n <= (phase_reg != sem_host_pkg::ST_WRITE);
      data_oe      <= (phase_reg == sem_host_pkg::ST_WRITE || phase_reg == sem_host_pkg::ST_WEND);
      // OE drops in every gap so each poll relatches the flag
      output_enable_n <= (phase_reg != sem_host_pkg::ST_READ);
    end
  end
endmodule
`default_nettype wire

/* File: tb/sem_host_monitor.sv */
`default_nettype none
module sem_host_monitor (
  input wire logic                            sys_clk,
  input wire logic                            rst,
  input wire logic                            cmd_valid,
  input wire logic [1:0]                      cmd_op,
  input wire logic                            cmd_ready,
  input wire logic                            done,
  input wire logic                            chip_enable_n,
  input wire logic                            semaphore_select_n,
  input wire logic                            output_enable_n,
  input wire logic                            read_write_n,
  input wire logic [sem_host_pkg::ADDR_W-1:0] addr,
  input wire logic [sem_host_pkg::DATA_W-1:0] data_out,
  input wire logic                            data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wr_strobe;
    (!read_write_n && !semaphore_select_n && data_oe) [*6];
  endsequence
  sequence s_wr_end;
    read_write_n && semaphore_select_n;
  endsequence
  sequence s_rd_ctrl;
    !semaphore_select_n && read_write_n && !data_oe;
  endsequence
  sequence s_rd_hold;
    (!output_enable_n) [*8] ##1 (output_enable_n && semaphore_select_n) [*2];
  endsequence
  sequence s_acq_take;
    cmd_valid && cmd_ready && cmd_op == sem_host_pkg::OP_ACQUIRE;
  endsequence
  sequence s_wr_soon;
    output_enable_n throughout (##[1:4] $fell(read_write_n));
  endsequence
  AST_CE_IDLE: assert property (chip_enable_n)
    else $error("array select driven low");
  AST_ADDR_HIGH: assert property (!semaphore_select_n |-> addr[11:3] == 9'h000)
    else $error("upper address bits set");
  AST_DATA_REPL: assert property (data_oe |-> data_out == {16{data_out[0]}})
    else $error("write data bits differ");
  AST_RD_CTRL: assert property (!output_enable_n |-> s_rd_ctrl)
    else $error("read strobe without select");
  AST_WR_SEQ: assert property ($fell(read_write_n) |-> s_wr_strobe ##1 s_wr_end)
    else $error("write strobe shape wrong");
  AST_RD_GAP: assert property ($fell(output_enable_n) |-> s_rd_hold)
    else $error("read not followed by idle gap");
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  AST_WR_FIRST: assert property (s_acq_take |-> s_wr_soon)
    else $error("acquire did not write first");
endmodule
bind sem_host sem_host_monitor mon_i (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_ready(cmd_ready), .done(done), .chip_enable_n(chip_enable_n),
  .semaphore_select_n(semaphore_select_n), .output_enable_n(output_enable_n),
  .read_write_n(read_write_n), .addr(addr), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

/* File: tb/sem_dev_model.sv */
`default_nettype none
module sem_dev_model (
  input  wire logic        sem_n,
  input  wire logic        oe_n,
  input  wire logic        rw_n,
  input  wire logic [11:0] addr,
  input  wire logic [15:0] din,
  output var  logic [15:0] dout,
  input  wire logic        b_stb,
  input  wire logic [2:0]  b_idx,
  input  wire logic        b_val
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // Latches: 0 free, 1 host side, 2 far side
  logic [7:0] req_a = 8'hff; // Stale requests at power-up
  logic [7:0] req_b = 8'h00;
  logic [1:0] tok [8];
  logic       q = 1'b1;
  logic       last = 1'b1;
  wire        wr_n = sem_n | rw_n;
  wire        rd_n = sem_n | oe_n | ~rw_n;
  function automatic void settle(int i);
    if (tok[i] == 2'd1 && !req_a[i]) tok[i] = req_b[i] ? 2'd2 : 2'd0;
    if (tok[i] == 2'd2 && !req_b[i]) tok[i] = req_a[i] ? 2'd1 : 2'd0;
    if (tok[i] == 2'd0) tok[i] = req_a[i] ? 2'd1 : (req_b[i] ? 2'd2 : 2'd0);
  endfunction
  initial for (int i = 0; i < 8; i++) begin
    tok[i] = 2'd0;
    settle(i);
  end
  always @(posedge wr_n) if (!$isunknown({addr[2:0], din[0]})) begin
    req_a[addr[2:0]] = ~din[0];
    settle(addr[2:0]);
  end
  always @(posedge b_stb) begin
    req_b[b_idx] = ~b_val;
    settle(b_idx);
  end
  always @(negedge rd_n) q = (tok[addr[2:0]] != 2'd1);
  always @(posedge rd_n) last = q;
  assign dout = !rd_n ? {16{q}} : {16{~last}}; // No wait output at all
endmodule
`default_nettype wire

/* File: tb/sem_host_test.sv */
`default_nettype none
module sem_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // Signals
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic [1:0]  cmd_op = 2'h0;
  logic [2:0]  cmd_index = 3'h0;
  logic        cmd_ready, done, granted, flag_value, read_mismatch;
  logic        ce_n, sem_n, oe_n, rw_n, data_oe;
  logic [11:0] addr;
  logic [15:0] data_in, data_out, dev_q;
  logic        b_stb = 1'b0;
  logic [2:0]  b_idx = 3'h0;
  logic        b_val = 1'b1;
  int          err_total = 0;
  int          checks = 0;
  always #5 sys_clk = ~sys_clk;
  assign data_in = data_oe ? data_out : dev_q;
  sem_host #(.POLL_LIMIT(8'h02)) sem_host_i (.sys_clk(sys_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_index(cmd_index), .cmd_ready(cmd_ready),
    .done(done), .granted(granted), .flag_value(flag_value), .read_mismatch(read_mismatch),
    .chip_enable_n(ce_n), .semaphore_select_n(sem_n), .output_enable_n(oe_n),
    .read_write_n(rw_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe));
  sem_dev_model sem_dev_model_i (.sem_n(sem_n), .oe_n(oe_n), .rw_n(rw_n), .addr(addr),
    .din(data_out), .dout(dev_q), .b_stb(b_stb), .b_idx(b_idx), .b_val(b_val));
  // =====
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [1:0] op, input logic [2:0] idx);
    int n;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_index = idx;
    for (n = 0; n < 3000 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge sys_clk);
    chk(16'(n < 3000), 16'h1);
  endtask
  task automatic b_write(input logic [2:0] idx, input logic val);
    @(negedge sys_clk);
    b_idx = idx;
    b_val = val;
    b_stb = 1'b1;
    @(negedge sys_clk);
    b_stb = 1'b0;
  endtask
  task automatic t_init();
    for (int i = 0; i < 8; i++) begin
      cmd(sem_host_pkg::OP_READ, 3'(i));
      chk(16'(flag_value), 16'(sem_host_pkg::FLAG_FREE));
      chk(16'(read_mismatch), 16'h0);
    end
  endtask
  task automatic t_handover();
    cmd(sem_host_pkg::OP_ACQUIRE, 3'h3);
    chk(16'(granted), 16'h1);
    b_write(3'h3, 1'b0);
    cmd(sem_host_pkg::OP_READ, 3'h3);
    chk(16'(flag_value), 16'(sem_host_pkg::FLAG_TAKEN));
    cmd(sem_host_pkg::OP_RELEASE, 3'h3);
    cmd(sem_host_pkg::OP_ACQUIRE, 3'h3);
    chk(16'(granted), 16'h0);
    b_write(3'h3, 1'b1);
    cmd(sem_host_pkg::OP_READ, 3'h3);
    chk(16'(flag_value), 16'(sem_host_pkg::FLAG_FREE));
    cmd(sem_host_pkg::OP_ACQUIRE, 3'h3);
    chk(16'(granted), 16'h1);
    cmd(sem_host_pkg::OP_RELEASE, 3'h3);
  endtask
  task automatic t_index();
    cmd(sem_host_pkg::OP_ACQUIRE, 3'h7);
    chk(16'(granted), 16'h1);
    cmd(sem_host_pkg::OP_READ, 3'h6);
    chk(16'(flag_value), 16'(sem_host_pkg::FLAG_FREE));
    cmd(sem_host_pkg::OP_RELEASE, 3'h7);
    b_write(3'h7, 1'b0);
    cmd(sem_host_pkg::OP_ACQUIRE, 3'h7);
    chk(16'(granted), 16'h0);
    b_write(3'h7, 1'b1);
    cmd(sem_host_pkg::OP_ACQUIRE, 3'h2);
    chk(16'(granted), 16'h1);
    cmd(sem_host_pkg::OP_INIT, 3'h5);
    cmd(sem_host_pkg::OP_READ, 3'h2);
    chk(16'(flag_value), 16'(sem_host_pkg::FLAG_FREE));
  endtask
  task automatic finish_test();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // =====
  // Run
  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    t_init();
    t_handover();
    t_index();
    finish_test();
  end
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
